// ### hw/crt_video_timing_generator.sv
// Purpose: raster video timing, sync, blanking and line reload request
// Assumes: clk is the divided video clock; settings held stable and legal
// Notes: outputs are active-high levels, reload is one pulse per line
`timescale 1ns/1ps
module crt_video_timing_generator
	import crt_timing_pkg::*;
#(
	parameter int unsigned hw = h_width,
	parameter int unsigned vw = v_width
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// horizontal settings, video clocks minus one
	input wire logic [hw-1:0] h_end_sync,
	input wire logic [hw-1:0] h_end_blank,
	input wire logic [hw-1:0] h_start_blank,
	input wire logic [hw-1:0] h_total,
	// vertical settings, lines minus one
	input wire logic [vw-1:0] v_end_sync,
	input wire logic [vw-1:0] v_end_blank,
	input wire logic [vw-1:0] v_start_blank,
	input wire logic [vw-1:0] v_total,
	// mode
	input wire logic interlace_en,
	// monitor side
	output logic hsync,
	output logic vsync,
	output logic blank,
	// memory side
	output logic reload_req,
	output logic [vw:0] reload_line_q,
	output logic odd_field_q,
	output logic frame_done
);
	// counters and compare state from the two axes
	logic [hw-1:0] h_count;
	logic [vw-1:0] v_count;
	logic h_sync_q;
	logic h_blank_q;
	logic h_wrap;
	phase_t h_phase;
	logic v_sync_q;
	logic v_blank_q;
	logic v_wrap;
	phase_t v_phase;
	// raw compares of the counters
	logic h_at_end_blank;
	logic h_at_start_blank;
	logic v_at_end_blank;
	logic v_at_start_blank;
	// compares gated by where each axis stands
	logic h_blank_end;
	logic h_blank_start;
	logic v_blank_end;
	logic v_blank_start;
	logic last_blank_line;
	logic even_field_end;
	// field state
	logic odd_field_d;
	// line reload state
	logic [vw:0] line_step;
	logic [vw:0] field_first_line;
	logic [vw:0] reload_line_d;
	logic reload_d;
	logic reload_q;
	// blanking output state
	logic h_blank_nx;
	logic v_blank_nx;
	logic blank_d;
	logic blank_q;

	sync_axis #(.width(hw)) h_axis (
		.clk(clk),
		.sys_rst(sys_rst),
		.step(1'b1),
		.end_sync(h_end_sync),
		.end_blank(h_end_blank),
		.start_blank(h_start_blank),
		.total(h_total),
		.count_q(h_count),
		.sync_q(h_sync_q),
		.blank_q(h_blank_q),
		.wrap(h_wrap),
		.phase_q(h_phase)
	);

	sync_axis #(.width(vw)) v_axis (
		.clk(clk),
		.sys_rst(sys_rst),
		.step(h_wrap),
		.end_sync(v_end_sync),
		.end_blank(v_end_blank),
		.start_blank(v_start_blank),
		.total(v_total),
		.count_q(v_count),
		.sync_q(v_sync_q),
		.blank_q(v_blank_q),
		.wrap(v_wrap),
		.phase_q(v_phase)
	);

	// monitor and memory outputs
	assign hsync = h_sync_q;
	assign vsync = v_sync_q;
	assign blank = blank_q;
	assign reload_req = reload_q;
	// a frame ends with the even field when interlaced
	assign frame_done = v_wrap && even_field_end;

	// raw compares, the same ones the axes act on
	assign h_at_end_blank = h_count == h_end_blank;
	assign h_at_start_blank = h_count == h_start_blank;
	assign v_at_end_blank = v_count == v_end_blank;
	assign v_at_start_blank = v_count == v_start_blank;

	// a compare counts only in its own phase
	assign h_blank_end = (h_phase == ph_back) && h_at_end_blank;
	assign h_blank_start = (h_phase == ph_active) && h_at_start_blank;
	assign v_blank_end = h_wrap && (v_phase == ph_back) && v_at_end_blank;
	assign v_blank_start = h_wrap && (v_phase == ph_active) && v_at_start_blank;
	assign last_blank_line = (v_phase == ph_back) && v_at_end_blank;
	assign even_field_end = !interlace_en || !odd_field_q;

	// each vertical scan is one field
	always_comb begin
		odd_field_d = odd_field_q;
		if (v_wrap) begin
			if (interlace_en) begin
				odd_field_d = !odd_field_q;
			end else begin
				odd_field_d = 1'b1;
			end
		end
	end

	// field bit starts odd so the first interlaced field shows odd lines
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			odd_field_q <= 1'b1;
		end else begin
			odd_field_q <= odd_field_d;
		end
	end

	// one reload as horizontal blank starts, blanked lines too
	always_comb begin
		reload_line_d = reload_line_q;
		reload_d = 1'b0;
		// interlaced: odd lines first, then even, stepping by two; else stepping by one
		line_step = (vw+1)'(1);
		field_first_line = '0;
		if (interlace_en) begin
			line_step = (vw+1)'(2);
			field_first_line = {{vw{1'b0}}, odd_field_q};
		end
		if (h_blank_start) begin
			reload_d = 1'b1;
			// last blanked line loads the first shown line
			if (last_blank_line) begin
				reload_line_d = field_first_line;
			end else begin
				reload_line_d = reload_line_q + line_step;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reload_line_q <= '0;
			reload_q <= 1'b0;
		end else begin
			reload_line_q <= reload_line_d;
			reload_q <= reload_d;
		end
	end

	// blank from one flop, so no glitch where the two axes meet
	always_comb begin
		h_blank_nx = h_blank_q;
		v_blank_nx = v_blank_q;
		if (h_blank_end) begin
			h_blank_nx = 1'b0;
		end
		if (h_blank_start) begin
			h_blank_nx = 1'b1;
		end
		if (v_blank_end) begin
			v_blank_nx = 1'b0;
		end
		if (v_blank_start) begin
			v_blank_nx = 1'b1;
		end
		blank_d = h_blank_nx | v_blank_nx;
	end

	// both axes leave reset blanked
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			blank_q <= 1'b1;
		end else begin
			blank_q <= blank_d;
		end
	end
endmodule

// ### hw/sync_axis.sv
// Purpose: one axis of the raster, counter plus compare sequence
// Assumes: end_sync < end_blank < start_blank < total
// Notes: used once for lines (clocks) and once for frames (lines)
`timescale 1ns/1ps
module sync_axis
	import crt_timing_pkg::*;
#(
	parameter int unsigned width = 12
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// count enable, tied high for the clock axis, from the faster axis otherwise
	input wire logic step,
	// settings
	input wire logic [width-1:0] end_sync,
	input wire logic [width-1:0] end_blank,
	input wire logic [width-1:0] start_blank,
	input wire logic [width-1:0] total,
	// state
	output logic [width-1:0] count_q,
	output logic sync_q,
	output logic blank_q,
	output logic wrap,
	output phase_t phase_q
);
	logic [width-1:0] count_d;
	logic sync_d;
	logic blank_d;
	phase_t phase_d;

	assign wrap = step && (count_q == total);

	always_comb begin
		count_d = count_q;
		sync_d = sync_q;
		blank_d = blank_q;
		phase_d = phase_q;
		if (step) begin
			count_d = count_q + {{(width-1){1'b0}}, 1'b1};
			unique case (phase_q)
				ph_sync: begin
					if (count_q == end_sync) begin
						sync_d = 1'b0;
						phase_d = ph_back;
					end
				end
				ph_back: begin
					if (count_q == end_blank) begin
						blank_d = 1'b0;
						phase_d = ph_active;
					end
				end
				ph_active: begin
					if (count_q == start_blank) begin
						blank_d = 1'b1;
						phase_d = ph_front;
					end
				end
				ph_front: begin
					if (count_q == total) begin
						sync_d = 1'b1;
						count_d = '0;
						phase_d = ph_sync;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			count_q <= '0;
			sync_q <= 1'b1;
			blank_q <= 1'b1;
			phase_q <= ph_sync;
		end else begin
			count_q <= count_d;
			sync_q <= sync_d;
			blank_q <= blank_d;
			phase_q <= phase_d;
		end
	end
endmodule

// ### inc/crt_timing_pkg.sv
// Purpose: shared constants for the raster timing generator
// Assumes: settings are counts minus one, all distinct, ascending
// Notes: defaults give a 108 clock by 512 line raster
package crt_timing_pkg;
	localparam int unsigned h_width = 12;
	localparam int unsigned v_width = 11;
	// default horizontal settings in video clocks, minus one
	localparam logic [11:0] h_end_sync_rst = 12'h008;
	localparam logic [11:0] h_end_blank_rst = 12'h014;
	localparam logic [11:0] h_start_blank_rst = 12'h064;
	localparam logic [11:0] h_total_rst = 12'h06b;
	// default vertical settings in lines, minus one
	localparam logic [10:0] v_end_sync_rst = 11'h006;
	localparam logic [10:0] v_end_blank_rst = 11'h01d;
	localparam logic [10:0] v_start_blank_rst = 11'h1fd;
	localparam logic [10:0] v_total_rst = 11'h1ff;
	// pixels per video clock in the usual setup
	localparam int unsigned pixels_per_clock = 8;
	typedef enum logic [1:0] {ph_sync, ph_back, ph_active, ph_front} phase_t;
endpackage

// ### tb/crt_timing_asserts.sv
// Purpose: port checks of the raster generator
// Assumes: settings legal, stable from reset release
// Notes: hc mirrors the clock counter from the ports alone
`timescale 1ns/1ps
module crt_timing_asserts #(
	parameter int unsigned hw = 12
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// settings
	input wire logic [hw-1:0] h_end_sync,
	input wire logic [hw-1:0] h_start_blank,
	input wire logic [hw-1:0] h_total,
	// outputs
	input wire logic hsync,
	input wire logic vsync,
	input wire logic blank,
	input wire logic reload_req,
	input wire logic frame_done
);
	logic [hw-1:0] hc_q;
	logic [hw-1:0] hc_d;
	always_comb begin
		hc_d = (sys_rst || hc_q == h_total) ? '0 : hc_q + hw'(1);
	end
	always_ff @(posedge clk) begin
		hc_q <= hc_d;
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_pulse;
		reload_req ##1 !reload_req;
	endsequence
	a_hsync_end: assert property (hc_q == h_end_sync |=> !hsync) else $error("hsync late");
	a_hsync_start: assert property (hc_q == h_total |=> hsync) else $error("hsync missing");
	a_reload_pulse: assert property (hc_q == h_start_blank |=> s_pulse) else $error("bad reload");
	a_reload_when: assert property (hc_q != h_start_blank |=> !reload_req) else $error("stray reload");
	a_hsync_blank: assert property (hsync |-> blank) else $error("sync unblanked");
	a_vsync_blank: assert property (vsync |-> blank) else $error("vsync unblanked");
	a_vsync_line: assert property ($rose(vsync) |-> $rose(hsync)) else $error("vsync off line");
	a_frame_end: assert property (frame_done |=> $rose(vsync)) else $error("frame end");
endmodule

// ### tb/crt_video_timing_generator_tb_top.sv
// Purpose: frame level bench of the raster generator
// Assumes: 7 line raster, 3 active lines
// Notes: every frame run starts from reset
`timescale 1ns/1ps
module crt_video_timing_generator_tb_top;
	logic clk = 0;
	logic sys_rst = 1;
	logic interlace_en = 0;
	logic [11:0] h_end_sync = '0, h_end_blank = '0, h_start_blank = '0, h_total = '0;
	logic [10:0] v_end_sync = 11'h001, v_end_blank = 11'h002, v_start_blank = 11'h005, v_total = 11'h006;
	logic hsync, vsync, blank, reload_req, odd_field_q, frame_done;
	logic [11:0] reload_line_q;
	logic [15:0] words_q, loads_q;
	int errors = 0, compares = 0, hs, vs, fd, od;
	// reload lines seen, one nibble per reload
	logic [63:0] lq;
	// settings, then hsync and word counts
	logic [79:0] rows [3] = '{80'h001_003_006_008_000e_0009, 80'h001_002_003_004_000e_0003,
		{crt_timing_pkg::h_end_sync_rst, crt_timing_pkg::h_end_blank_rst, crt_timing_pkg::h_start_blank_rst,
		crt_timing_pkg::h_total_rst, 32'h003f_00f0}};
	crt_video_timing_generator u_crt_video_timing_generator (
		.clk(clk),
		.sys_rst(sys_rst),
		.h_end_sync(h_end_sync),
		.h_end_blank(h_end_blank),
		.h_start_blank(h_start_blank),
		.h_total(h_total),
		.v_end_sync(v_end_sync),
		.v_end_blank(v_end_blank),
		.v_start_blank(v_start_blank),
		.v_total(v_total),
		.interlace_en(interlace_en),
		.hsync(hsync),
		.vsync(vsync),
		.blank(blank),
		.reload_req(reload_req),
		.reload_line_q(reload_line_q),
		.odd_field_q(odd_field_q),
		.frame_done(frame_done)
	);
	pixel_shifter u_pixel_shifter (
		.clk(clk),
		.sys_rst(sys_rst),
		.blank(blank),
		.reload_req(reload_req),
		.words_q(words_q),
		.loads_q(loads_q)
	);
	initial begin
		forever #2 clk = ~clk;
	end
	task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %0h seen %0h", n, exp, seen);
		end
	endtask
	task frame(input int n);
		sys_rst = 1;
		repeat (8) @(negedge clk);
		sys_rst = 0;
		hs = 0;
		vs = 0;
		fd = 0;
		od = 0;
		lq = '0;
		repeat (n) begin
			hs += int'(hsync === 1'b1);
			vs += int'(vsync === 1'b1);
			fd += int'(frame_done === 1'b1);
			od += int'(odd_field_q === 1'b1);
			if (reload_req === 1'b1) begin
				lq = {lq[59:0], reload_line_q[3:0]};
			end
			@(negedge clk);
		end
	endtask
	task test_done;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		@(negedge clk);
		foreach (rows[i]) begin
			{h_end_sync, h_end_blank, h_start_blank, h_total} = rows[i][79:32];
			frame((int'(h_total) + 1) * 7);
			chk("hsync", hs, rows[i][31:16]);
			chk("words", words_q, rows[i][15:0]);
			chk("loads", loads_q, 32'h7);
			chk("vsync", vs, 2 * (int'(h_total) + 1));
			chk("frame", fd, 32'h1);
			chk("odd", od, 7 * (int'(h_total) + 1));
			chk("line", lq[31:0], 32'h01201234);
		end
		// mid-field reset, then two interlaced fields
		interlace_en = 1;
		{h_end_sync, h_end_blank, h_start_blank, h_total} = rows[0][79:32];
		frame(40);
		sys_rst = 1;
		@(negedge clk);
		chk("rst", {hsync, vsync, blank, reload_req, odd_field_q, reload_line_q}, 32'h1d000);
		frame(126);
		chk("frame", fd, 32'h1);
		chk("odd", od, 32'h3f);
		chk("loads", loads_q, 32'he);
		chk("line_hi", lq[63:32], 32'h00241357);
		chk("line_lo", lq[31:0], 32'h9bd02468);
		test_done;
	end
endmodule
bind crt_video_timing_generator crt_timing_asserts #(.hw(hw)) u_crt_timing_asserts (
	.clk(clk),
	.sys_rst(sys_rst),
	.h_end_sync(h_end_sync),
	.h_start_blank(h_start_blank),
	.h_total(h_total),
	.hsync(hsync),
	.vsync(vsync),
	.blank(blank),
	.reload_req(reload_req),
	.frame_done(frame_done)
);

// ### tb/pixel_shifter.sv
// Purpose: far side, shown word tally and reload tally
// Assumes: one word of eight pixels per video clock
// Notes: counts only, the bench judges them
`timescale 1ns/1ps
module pixel_shifter (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// from the generator
	input wire logic blank,
	input wire logic reload_req,
	// tallies
	output logic [15:0] words_q,
	output logic [15:0] loads_q
);
	logic [15:0] words_d;
	logic [15:0] loads_d;
	always_comb begin
		words_d = sys_rst ? '0 : words_q + 16'(!blank);
		loads_d = sys_rst ? '0 : loads_q + 16'(reload_req);
	end
	always_ff @(posedge clk) begin
		words_q <= words_d;
		loads_q <= loads_d;
	end
endmodule
